// [logic/cfg_bank_defines.svh]
// Offsets, field positions, masks, reset values and counts of the config bank
`ifndef CFG_BANK_DEFINES_SVH
`define CFG_BANK_DEFINES_SVH

// Register offsets (15-bit serial address)
`define OFF_SERIAL_CONTROL   15'h0000
`define OFF_TUNING_WORD_LOW  15'h003F
`define OFF_PHASE_OFFSET     15'h0043
`define OFF_TRIGGER_DELAY    15'h0044
`define OFF_SYNTH_CONFIG     15'h0045
`define OFF_TUNING_SHIFT     15'h0047
`define OFF_START_DELAY      15'h005C
`define OFF_FIRST_ADDRESS    15'h005D
`define OFF_LAST_ADDRESS     15'h005E
`define OFF_CYCLE_COUNT      15'h005F
`define OFF_ERROR_FLAGS      15'h0060
`define MEM_BASE_HI          3'h6
`define MEM_DEPTH            4096
`define MEM_AW               12
`define MEM_DW               12

// Serial control bit positions
`define BIT_ORDER_POS        15
`define WIRE_COUNT_POS       14
`define SOFT_RESET_POS       13
`define DUAL_LINE_POS        12
`define SOFT_RESET_COPY_POS  2

// Writable bits per register, reserved bits stay zero
`define WM_SERIAL_CONTROL    16'hFC3F
`define WM_TUNING_WORD_LOW   16'hFF00
`define WM_PHASE_OFFSET      16'hFFFF
`define WM_TRIGGER_DELAY     16'h0002
`define WM_SYNTH_CONFIG      16'h000F
`define WM_TUNING_SHIFT      16'h001F
`define WM_START_DELAY       16'hFFFF
`define WM_FIRST_ADDRESS     16'hFFF0
`define WM_LAST_ADDRESS      16'hFFF0
`define WM_CYCLE_COUNT       16'hFFFF
`define RM_ERROR_FLAGS       16'h003F

// Reset values
`define RST_ZERO             16'h0000
`define RST_CYCLE_COUNT      16'h0001

// Bank geometry and frame timing in serial clocks
`define NUM_REGS             10
`define IDX_NONE             4'hF
`define INSTR_BITS           6'h10
`define END_SINGLE           6'h20
`define END_DUAL             6'h18
`endif

// [logic/cfg_bank_pkg.sv]
// Types shared by the config bank files
package cfg_bank_pkg;
  // Core-clock state
  typedef struct packed {
    logic [9:0][15:0] regs;     // Register array, index 0 is serial control
    logic [15:0]      rd_word;  // Word returned to the serial side
    logic [1:0]       wr_sync;  // Write toggle synchroniser
    logic [1:0]       rd_sync;  // Read toggle synchroniser
    logic             wr_prev;  // Last seen write toggle
    logic             rd_prev;  // Last seen read toggle
    logic             mem_pend; // Memory read in flight
    logic             srst;     // Soft reset pulse
  } core_state_t;

  // Link state that lives across frames
  typedef struct packed {
    logic        wr_tgl;        // Write request toggle
    logic        rd_tgl;        // Read request toggle
    logic [14:0] addr_h;        // Held address
    logic [15:0] data_h;        // Held write data
    logic [1:0]  lsb_s;         // Bit order synchroniser
    logic [1:0]  w3_s;          // Wire count synchroniser
    logic [1:0]  dl_s;          // Dual line synchroniser
  } link_keep_t;

  // Link state cleared whenever chip select is high
  typedef struct packed {
    logic [5:0]  cnt;           // Serial clocks seen in this frame
    logic [15:0] sh;            // Input shift register
    logic [15:0] osh;           // Output shift register
    logic        rd;            // Frame is a read
    logic        dual;          // Data phase uses both lines
  } frame_state_t;
endpackage

// [logic/pattern_store.sv]
// Pattern memory, one port, registered read data
`timescale 1ns/100ps
`include "cfg_bank_defines.svh"
module pattern_store (
  input  wire logic                  ref_clk,
  input  wire logic                  we,
  input  wire logic [`MEM_AW-1:0]    addr,
  input  wire logic [`MEM_DW-1:0]    wdata,
  output logic      [`MEM_DW-1:0]    rdata_q
);
  // Storage array, no reset so it maps onto a RAM
  logic [`MEM_DW-1:0] mem [0:`MEM_DEPTH-1];

  // Read first: the old word is read every cycle, a write lands after it
  always_ff @(posedge ref_clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata_q <= mem[addr];
  end
endmodule // pattern_store

// [logic/serial_config_register_bank.sv]
// Serial-port configuration register bank with pattern memory window
`timescale 1ns/100ps
`include "cfg_bank_defines.svh"
module serial_config_register_bank (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe,
  input  wire logic        sdio2_in,
  output logic             sdio2_out,
  output logic             sdio2_oe,
  output logic             sdo_out,
  output logic             sdo_oe,
  input  wire logic [5:0]  err_flags,
  output logic             soft_reset_pulse,
  output logic [7:0]       tuning_word_low,
  output logic [15:0]      phase_offset,
  output logic             trigger_delay_en,
  output logic [3:0]       synth_enables,
  output logic [4:0]       tuning_shift,
  output logic [15:0]      start_delay,
  output logic [11:0]      first_address,
  output logic [11:0]      last_address,
  output logic [15:0]      cycle_count
);
  // Register index of an address, shared by read and write decode
  function automatic logic [3:0] reg_index(input logic [14:0] a);
    if (a == `OFF_SERIAL_CONTROL) reg_index = 4'h0;
    else if (a == `OFF_TUNING_WORD_LOW) reg_index = 4'h1;
    else if (a == `OFF_PHASE_OFFSET) reg_index = 4'h2;
    else if (a == `OFF_TRIGGER_DELAY) reg_index = 4'h3;
    else if (a == `OFF_SYNTH_CONFIG) reg_index = 4'h4;
    else if (a == `OFF_TUNING_SHIFT) reg_index = 4'h5;
    else if (a == `OFF_START_DELAY) reg_index = 4'h6;
    else if (a == `OFF_FIRST_ADDRESS) reg_index = 4'h7;
    else if (a == `OFF_LAST_ADDRESS) reg_index = 4'h8;
    else if (a == `OFF_CYCLE_COUNT) reg_index = 4'h9;
    else reg_index = `IDX_NONE;
  endfunction

  // Pattern memory window test
  function automatic logic is_mem(input logic [14:0] a);
    is_mem = (a[14:12] == `MEM_BASE_HI);
  endfunction

  // Writable bits of a register
  function automatic logic [15:0] wmask(input logic [3:0] i);
    case (i)
      4'h0: wmask = `WM_SERIAL_CONTROL;
      4'h1: wmask = `WM_TUNING_WORD_LOW;
      4'h2: wmask = `WM_PHASE_OFFSET;
      4'h3: wmask = `WM_TRIGGER_DELAY;
      4'h4: wmask = `WM_SYNTH_CONFIG;
      4'h5: wmask = `WM_TUNING_SHIFT;
      4'h6: wmask = `WM_START_DELAY;
      4'h7: wmask = `WM_FIRST_ADDRESS;
      4'h8: wmask = `WM_LAST_ADDRESS;
      default: wmask = `WM_CYCLE_COUNT;
    endcase
  endfunction

  // Default value of a register
  function automatic logic [15:0] rst_val(input int i);
    rst_val = (i == 9) ? `RST_CYCLE_COUNT : `RST_ZERO;
  endfunction

  // Shift one serial input step into a word
  function automatic logic [15:0] shift_in(input logic [15:0] s, input logic d0,
                                           input logic d1, input logic lsb,
                                           input logic dual);
    if (dual)
      shift_in = lsb ? {d0, s[15:9], d1, s[7:1]} : {s[14:8], d0, s[6:0], d1};
    else
      shift_in = lsb ? {d0, s[15:1]} : {s[14:0], d0};
  endfunction

  // Advance an output word by one serial step
  function automatic logic [15:0] shift_out(input logic [15:0] w, input logic lsb,
                                            input logic dual);
    if (dual)
      shift_out = lsb ? {1'b0, w[15:9], 1'b0, w[7:1]} : {w[14:8], 1'b0, w[6:0], 1'b0};
    else
      shift_out = lsb ? {1'b0, w[15:1]} : {w[14:0], 1'b0};
  endfunction

  // Core-domain state and its next value
  cfg_bank_pkg::core_state_t  c_q;
  cfg_bank_pkg::core_state_t  c_d;
  // Link-domain state across frames and within a frame
  cfg_bank_pkg::link_keep_t   k_q;
  cfg_bank_pkg::link_keep_t   k_d;
  cfg_bank_pkg::frame_state_t f_q;
  cfg_bank_pkg::frame_state_t f_d;

  logic                lnk_rst_n;  // Frame reset, also released only by cs_n low
  logic                mem_we;     // Pattern memory write strobe
  logic [`MEM_DW-1:0]  mem_rdata;  // Pattern memory read data
  logic                wr_evt;     // Write request arrived in core domain
  logic                rd_evt;     // Read request arrived in core domain
  logic [3:0]          wr_idx;     // Decoded write target
  logic [3:0]          rd_idx;     // Decoded read target
  logic                lsb;        // Bit order seen by the link
  logic                w3;         // Three-wire mode seen by the link
  logic [5:0]          dend;       // Count at which the data phase ends
  logic                rd_act;     // Read data is being driven
  logic [15:0]         pw;         // Word whose next bits are on the pins

  // Pattern memory; address comes from the held link word, stable by handshake
  pattern_store u_store (
    .ref_clk (ref_clk),
    .we      (mem_we),
    .addr    (k_q.addr_h[`MEM_AW-1:0]),
    .wdata   (k_q.data_h[`MEM_DW-1:0]),
    .rdata_q (mem_rdata)
  );

  // Toggle edges after two-flop synchronisers
  assign wr_evt = c_q.wr_sync[1] ^ c_q.wr_prev;
  assign rd_evt = c_q.rd_sync[1] ^ c_q.rd_prev;
  assign wr_idx = reg_index(k_q.addr_h);
  assign rd_idx = reg_index(k_q.addr_h);

  // Core next state: register writes, soft reset, read capture
  always_comb
  begin
    c_d         = c_q;
    mem_we      = 1'b0;
    c_d.srst    = 1'b0;
    c_d.wr_sync = {c_q.wr_sync[0], k_q.wr_tgl};
    c_d.rd_sync = {c_q.rd_sync[0], k_q.rd_tgl};
    c_d.wr_prev = c_q.wr_sync[1];
    c_d.rd_prev = c_q.rd_sync[1];
    // Write request from the serial side
    if (wr_evt)
    begin
      if (wr_idx == 4'h0)
      begin
        // Reset request bits self-clear so they never latch the bank in reset
        c_d.regs[0] = k_q.data_h & `WM_SERIAL_CONTROL;
        c_d.regs[0][`SOFT_RESET_POS] = 1'b0;
        c_d.regs[0][`SOFT_RESET_COPY_POS] = 1'b0;
        if (k_q.data_h[`SOFT_RESET_POS])
        begin
          // Every register but serial control goes back to default
          for (int i = 1; i < `NUM_REGS; i++)
            c_d.regs[i] = rst_val(i);
          c_d.srst = 1'b1;
        end
      end
      else if (wr_idx != `IDX_NONE)
      begin
        // Reserved bits are dropped on the way in
        c_d.regs[wr_idx] = k_q.data_h & wmask(wr_idx);
      end
      else if (is_mem(k_q.addr_h))
      begin
        mem_we = 1'b1;
      end
    end
    // Read request: registers answer at once, memory one cycle later
    if (rd_evt)
    begin
      if (rd_idx != `IDX_NONE)
        c_d.rd_word = c_q.regs[rd_idx];
      else if (k_q.addr_h == `OFF_ERROR_FLAGS)
        c_d.rd_word = {10'h000, err_flags} & `RM_ERROR_FLAGS;
      else if (is_mem(k_q.addr_h))
        c_d.mem_pend = 1'b1;
      else
        c_d.rd_word = 16'h0000;
    end
    // Memory data lands in the answer word
    if (c_q.mem_pend)
    begin
      c_d.rd_word  = {4'h0, mem_rdata};
      c_d.mem_pend = 1'b0;
    end
  end

  // Core register stage
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c_q <= '0;
      c_q.regs[9] <= `RST_CYCLE_COUNT;
    end
    else
    begin
      c_q <= c_d;
    end
  end

  // Fields handed to the waveform engine
  assign soft_reset_pulse = c_q.srst;
  assign tuning_word_low  = c_q.regs[1][15:8];
  assign phase_offset     = c_q.regs[2];
  assign trigger_delay_en = c_q.regs[3][1];
  assign synth_enables    = c_q.regs[4][3:0];
  assign tuning_shift     = c_q.regs[5][4:0];
  assign start_delay      = c_q.regs[6];
  assign first_address    = c_q.regs[7][15:4];
  assign last_address     = c_q.regs[8][15:4];
  assign cycle_count      = c_q.regs[9];

  // Link side: mode bits come through two-flop synchronisers
  assign lsb  = k_q.lsb_s[1];
  assign w3   = k_q.w3_s[1];
  assign dend = f_q.dual ? `END_DUAL : `END_SINGLE;
  // Frame reset holds the frame state in reset while chip select is high
  assign lnk_rst_n = rst_n & ~cs_n;

  // Read data phase in progress
  assign rd_act = f_q.rd & (f_q.cnt >= `INSTR_BITS) & (f_q.cnt < dend);
  // First data bit comes straight from the held answer word
  assign pw = (f_q.cnt == `INSTR_BITS) ? c_q.rd_word : f_q.osh;

  // Link next state, one step per rising serial clock
  always_comb
  begin
    logic [15:0] ins;
    logic [15:0] wd;
    ins     = '0;
    wd      = '0;
    f_d     = f_q;
    k_d     = k_q;
    k_d.lsb_s = {k_q.lsb_s[0], c_q.regs[0][`BIT_ORDER_POS]};
    k_d.w3_s  = {k_q.w3_s[0], c_q.regs[0][`WIRE_COUNT_POS]};
    k_d.dl_s  = {k_q.dl_s[0], c_q.regs[0][`DUAL_LINE_POS]};
    if (f_q.cnt < `INSTR_BITS)
    begin
      // Instruction word: read flag and 15-bit address
      ins       = shift_in(f_q.sh, sdio_in, 1'b0, lsb, 1'b0);
      f_d.sh    = ins;
      f_d.cnt   = f_q.cnt + 6'h01;
      if (f_q.cnt == `INSTR_BITS - 6'h01)
      begin
        f_d.rd     = ins[15];
        // Dual lines only ever carry pattern memory words
        f_d.dual   = k_q.dl_s[1] & is_mem(ins[14:0]);
        k_d.addr_h = ins[14:0];
        if (ins[15])
          k_d.rd_tgl = ~k_q.rd_tgl;
      end
    end
    else if (f_q.cnt < dend)
    begin
      // Data word in or out; extra clocks after it are ignored
      f_d.cnt = f_q.cnt + 6'h01;
      if (f_q.rd)
      begin
        f_d.osh = shift_out(pw, lsb, f_q.dual);
      end
      else
      begin
        wd     = shift_in(f_q.sh, sdio_in, sdio2_in, lsb, f_q.dual);
        f_d.sh = wd;
        if (f_q.cnt == dend - 6'h01)
        begin
          k_d.data_h = wd;
          k_d.wr_tgl = ~k_q.wr_tgl;
        end
      end
    end
  end

  // Link state surviving frames
  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
      k_q <= '0;
    else
      k_q <= k_d;
  end

  // Frame state, cleared whenever chip select is high
  always_ff @(posedge sclk or negedge lnk_rst_n)
  begin
    if (!lnk_rst_n)
      f_q <= '0;
    else
      f_q <= f_d;
  end

  // Pin drive: one line in 3-wire, separate output in 4-wire, two in dual
  assign sdio_oe  = rd_act & (w3 | f_q.dual);
  assign sdo_oe   = rd_act & ~w3 & ~f_q.dual;
  assign sdio2_oe = rd_act & f_q.dual;
  assign sdio_out = f_q.dual ? (lsb ? pw[8] : pw[15]) : (lsb ? pw[0] : pw[15]);
  assign sdo_out  = lsb ? pw[0] : pw[15];
  assign sdio2_out = lsb ? pw[0] : pw[7];

  // Soft reset restores defaults one cycle after the write lands
  soft_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_evt && wr_idx == 4'h0 && k_q.data_h[`SOFT_RESET_POS]
    |=> c_q.regs[9] == `RST_CYCLE_COUNT && c_q.regs[2] == 16'h0000 && c_q.srst)
    else $error("soft reset did not restore defaults");

  // Serial control keeps the written value through soft reset
  control_kept_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_evt && wr_idx == 4'h0
    |=> c_q.regs[0][15:14] == $past(k_q.data_h[15:14])
        && c_q.regs[0][12] == $past(k_q.data_h[12]) && !c_q.regs[0][13])
    else $error("serial control not kept on write");

  // Reserved bits of serial control, trigger delay bits 15:2, synth config and first address never become set
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    c_q.regs[4][15:4] == 12'h000 && c_q.regs[3][15:2] == 14'h0000
    && c_q.regs[0][9:6] == 4'h0 && c_q.regs[7][3:0] == 4'h0)
    else $error("reserved bit set");

  // First read bit is MSB or LSB as the order bit says
  first_bit_a: assert property (@(posedge sclk) disable iff (!lnk_rst_n)
    rd_act && f_q.cnt == `INSTR_BITS && !f_q.dual
    |-> sdo_out == (lsb ? c_q.rd_word[0] : c_q.rd_word[15]))
    else $error("wrong first data bit");

  // Four-wire reads use the separate output only
  four_wire_a: assert property (@(posedge sclk) disable iff (!lnk_rst_n)
    rd_act && !w3 && !f_q.dual |-> sdo_oe && !sdio_oe && !sdio2_oe)
    else $error("four-wire drive wrong");

  // Three-wire reads turn the data line round
  three_wire_a: assert property (@(posedge sclk) disable iff (!lnk_rst_n)
    rd_act && w3 |-> sdio_oe && !sdo_oe)
    else $error("three-wire drive wrong");

  // Second line drives only for memory reads with dual enabled
  dual_gate_a: assert property (@(posedge sclk) disable iff (!lnk_rst_n)
    sdio2_oe |-> k_q.dl_s[1] && is_mem(k_q.addr_h) && f_q.rd)
    else $error("second line driven outside memory read");

  // Dual data phase lasts eight clocks
  dual_len_a: assert property (@(posedge sclk) disable iff (!lnk_rst_n)
    sdio2_oe && f_q.cnt == `INSTR_BITS |-> ##7 sdio2_oe && f_q.cnt == `END_DUAL - 6'h01)
    else $error("dual data phase length wrong");
endmodule // serial_config_register_bank

// [dv/serial_host.sv]
// Host model that drives the serial configuration port
`timescale 1ns/100ps
module serial_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      sdio_in,
  output logic      sdio2_in,
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  input  wire logic sdio2_out,
  input  wire logic sdio2_oe,
  input  wire logic sdo_out,
  input  wire logic sdo_oe
);
  logic        lsb;      // Host belief: LSB first
  logic        w3;       // Host belief: three-wire port
  logic        dl;       // Host belief: dual data lines
  logic        h0;       // Host level on line 0
  logic        h1;       // Host level on line 1
  logic [15:0] rd_word;  // Last word read
  event        rd_done;  // Read word ready for checking

  // Line level: device drive wins, else the host's own level
  assign sdio_in  = sdio_oe ? sdio_out : h0;
  assign sdio2_in = sdio2_oe ? sdio2_out : h1;

  // Clock stands low and select high between frames
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    {h0, h1, lsb, w3, dl} = 5'h08;
  end

  // One serial clock period
  task automatic pulse();
    #7.5 sclk = 1'b1;
    #7.5 sclk = 1'b0;
  endtask

  // One frame: instruction, pause on reads, one data word
  task automatic xfer(input logic rd, input logic [14:0] addr, input logic [15:0] wd);
    logic [15:0] ins;
    logic        two;
    int          n;
    int          k;
    ins = {rd, addr};
    two = dl && addr[14:12] == 3'h6;  // Dual lines only in the memory window
    n = two ? 8 : 16;
    // Last word is kept here; the bench reads it when this call raises rd_done at its end
    cs_n = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      h0 = ins[lsb ? i : 15 - i];
      pulse();
    end
    // Read word crosses to the link side during this pause
    if (rd)
      #250;
    for (int i = 0; i < n; i++)
    begin
      k = lsb ? i : n - 1 - i;
      // Released lines toggle so a stale level cannot pass
      h0 = rd ? ~h0 : wd[(two ? 8 : 0) + k];
      h1 = rd ? ~h1 : wd[k];
      #7.4;
      if (two)
      begin
        rd_word[k + 8] = sdio_in;
        rd_word[k] = sdio2_in;
      end
      else
        rd_word[k] = w3 ? sdio_in : sdo_out;
      #0.1 sclk = 1'b1;
      #7.5 sclk = 1'b0;
    end
    cs_n = 1'b1;
    h0 = ~h0;
    h1 = ~h1;
    // Gap lets a write land in the core before the next frame
    #200;
    if (rd)
      ->rd_done;
  endtask

  // Edges with select high so a new mode reaches the link logic
  task automatic tick();
    repeat (2) pulse();
    #200;
  endtask
endmodule // serial_host

// [dv/tb_serial_config_register_bank.sv]
// Self-checking bench for the serial configuration register bank
`timescale 1ns/100ps
`include "cfg_bank_defines.svh"
module tb_serial_config_register_bank;
  logic        ref_clk = 1'b0;    // Core clock
  logic        rst_n = 1'b0;      // Reset of both domains
  logic [5:0]  err_flags = 6'h00; // Engine error flags
  logic        sclk, cs_n, sdio_in, sdio2_in;
  logic        sdio_out, sdio_oe, sdio2_out, sdio2_oe, sdo_out, sdo_oe;
  logic        soft_reset_pulse, trigger_delay_en;
  logic [3:0]  synth_enables;
  logic [4:0]  tuning_shift;
  logic [7:0]  tuning_word_low;
  logic [11:0] first_address, last_address;
  logic [15:0] phase_offset, start_delay, cycle_count;
  logic [15:0] exp_q[$];          // Expected read words, oldest first
  string       name_q[$];         // What each note describes
  int          error_cnt = 0;     // Mismatches seen
  int          num_checks = 0;    // Comparisons made
  int          srst_cnt = 0;      // Soft reset pulses seen
  // Bank table: offset, writable mask, shift down to the port field
  logic [14:0] offs[9] = '{`OFF_TUNING_WORD_LOW, `OFF_PHASE_OFFSET, `OFF_TRIGGER_DELAY,
    `OFF_SYNTH_CONFIG, `OFF_TUNING_SHIFT, `OFF_START_DELAY, `OFF_FIRST_ADDRESS,
    `OFF_LAST_ADDRESS, `OFF_CYCLE_COUNT};
  logic [15:0] msk[9] = '{`WM_TUNING_WORD_LOW, `WM_PHASE_OFFSET, `WM_TRIGGER_DELAY,
    `WM_SYNTH_CONFIG, `WM_TUNING_SHIFT, `WM_START_DELAY, `WM_FIRST_ADDRESS,
    `WM_LAST_ADDRESS, `WM_CYCLE_COUNT};
  int          sh[9] = '{8, 0, 1, 0, 0, 0, 4, 4, 0};

  always #10 ref_clk = ~ref_clk;

  serial_config_register_bank dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdio2_in(sdio2_in), .sdio2_out(sdio2_out),
    .sdio2_oe(sdio2_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .err_flags(err_flags),
    .soft_reset_pulse(soft_reset_pulse), .tuning_word_low(tuning_word_low),
    .phase_offset(phase_offset), .trigger_delay_en(trigger_delay_en),
    .synth_enables(synth_enables), .tuning_shift(tuning_shift), .start_delay(start_delay),
    .first_address(first_address), .last_address(last_address), .cycle_count(cycle_count)
  );

  serial_host host_u (
    .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio2_in(sdio2_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .sdio2_out(sdio2_out), .sdio2_oe(sdio2_oe), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe)
  );

  // Count soft reset pulses in the core domain
  always @(posedge ref_clk)
    if (soft_reset_pulse === 1'b1)
      srst_cnt++;

  // Oldest note is compared with each word the host reads
  always @(host_u.rd_done)
    compare_val(name_q.pop_front(), exp_q.pop_front(), host_u.rd_word);

  task automatic compare_val(input string what, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  // Reads note the expected word before the frame goes out
  task automatic rd(input logic [14:0] a, input logic [15:0] e);
    name_q.push_back($sformatf("read %h", a));
    exp_q.push_back(e);
    host_u.xfer(1'b1, a, 16'h0000);
  endtask

  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    host_u.xfer(1'b0, a, d);
  endtask

  // Upper control bits always mirror the low six
  function automatic logic [15:0] mirror(input logic [5:0] lo);
    logic [5:0] r;
    for (int i = 0; i < 6; i++)
      r[i] = lo[5 - i];
    return {r, 4'h0, lo};
  endfunction

  // New mode applies only after the link logic has seen it
  task automatic set_mode(input logic [15:0] v);
    wr(`OFF_SERIAL_CONTROL, v);
    {host_u.lsb, host_u.w3, host_u.dl} = {v[15], v[14], v[12]};
    host_u.tick();
  endtask

  // Engine port of table entry i, widened to a word
  function automatic logic [15:0] port_of(input int i);
    case (i)
      0: return {8'h00, tuning_word_low};
      1: return phase_offset;
      2: return {15'h0000, trigger_delay_en};
      3: return {12'h000, synth_enables};
      4: return {11'h000, tuning_shift};
      5: return start_delay;
      6: return {4'h0, first_address};
      7: return {4'h0, last_address};
      default: return cycle_count;
    endcase
  endfunction

  task automatic check_defaults();
    for (int i = 0; i < 9; i++)
    begin
      rd(offs[i], i == 8 ? `RST_CYCLE_COUNT : `RST_ZERO);
      compare_val("port", i == 8 ? `RST_CYCLE_COUNT : `RST_ZERO, port_of(i));
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Cuts a hang short
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    error_cnt++;
    $display("mismatch run length expected end seen timeout");
    complete_run();
  end

  initial
  begin
    logic [15:0] v;
    logic [15:0] p;
    logic [11:0] a;
    int          b;
    void'($urandom(91));
    // Link clock gets edges while reset is held
    fork
      host_u.tick();
    join_none
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    err_flags <= 6'($urandom());
    repeat (2) @(posedge ref_clk);
    // Defaults, reserved bits, read-only and unmapped places
    check_defaults();
    for (int i = 0; i < 9; i++)
    begin
      v = 16'($urandom());
      wr(offs[i], v);
      rd(offs[i], v & msk[i]);
      compare_val("port", (v & msk[i]) >> sh[i], port_of(i));
    end
    wr(`OFF_ERROR_FLAGS, 16'hFFFF);
    rd(`OFF_ERROR_FLAGS, {10'h000, err_flags});
    wr(15'h0001, 16'hFFFF);
    rd(15'h0001, 16'h0000);
    $display("end of test: register access");
    // Soft reset keeps the control register, restores the rest to defaults
    set_mode(mirror(6'h10));
    b = srst_cnt;
    wr(`OFF_SERIAL_CONTROL, mirror(6'h14));
    compare_val("soft reset pulses", 16'h0001, 16'(srst_cnt - b));
    rd(`OFF_SERIAL_CONTROL, mirror(6'h10));
    check_defaults();
    set_mode(16'h0000);
    $display("end of test: soft reset");
    // Bit order, three-wire and dual-line modes
    set_mode(mirror(6'h01));
    rd(`OFF_SERIAL_CONTROL, mirror(6'h01));
    p = 16'($urandom());
    wr(`OFF_PHASE_OFFSET, p);
    rd(`OFF_PHASE_OFFSET, p);
    compare_val("phase port", p, phase_offset);
    set_mode(mirror(6'h02));
    rd(`OFF_SERIAL_CONTROL, mirror(6'h02));
    rd(`OFF_PHASE_OFFSET, p);
    for (int m = 0; m < 2; m++)
    begin
      set_mode(mirror(m == 0 ? 6'h08 : 6'h09));
      for (int i = 0; i < 3; i++)
      begin
        a = i == 0 ? 12'h000 : i == 1 ? 12'hFFF : 12'($urandom());
        v = 16'($urandom());
        wr({`MEM_BASE_HI, a}, v);
        rd({`MEM_BASE_HI, a}, v & 16'h0FFF);
      end
      rd(`OFF_PHASE_OFFSET, p);
    end
    set_mode(16'h0000);
    rd({`MEM_BASE_HI, a}, v & 16'h0FFF);
    $display("end of test: serial modes");
    for (int i = 0; i < 100 && exp_q.size() != 0; i++)
      @(posedge ref_clk);
    if (exp_q.size() != 0)
    begin
      error_cnt++;
      $display("mismatch read queue expected 0 seen %0d", exp_q.size());
    end
    complete_run();
  end
endmodule // tb_serial_config_register_bank
